// ===== hdl/csio_pkg.sv
// Package with register map, field layout and types of the clocked serial block
// Overview of operation
// - Internal clock mode drives serial clock out at one of seven rates.
// - Clock select value 111 follows the clock arriving on the pin.
// - Internal clock pin idles and starts each transfer high.
// - Internal clock stops while buffer awaits service.
// - Data out changes on falling edge, data in sampled on rising edge.
// - Two-bit mode field picks transmit, receive or both.
// - Start bit sends loaded byte, least significant bit first.
// - Moving byte to shifter empties buffer; in transmit mode it also raises interrupt.
// - Internal clock transmit waits after eight bits until buffer written.
// - Previous last bit stays on data out until first falling edge.
// - Clearing start bit finishes pending data, then clears active flag.
// - Inhibit bit aborts at once and clears active flag.
// - External clock without start cleared keeps sending dummy data each byte.
// - Receive shifts eight bits, stores byte, raises buffer-full interrupt.
// - Clearing start in receive completes current byte, then clears flag.
// - Aborted reception data is invalid and need not be read.
// - Transmit/receive shares one buffer and interrupts after each frame.
// - Clearing start in duplex completes current byte, then clears flag.
// - Last transmitted bit holds on data out after final rising edge.
// - Interface mode field: 00 port, 01 clocked serial, 10 two-wire.
// - Status bit 3 shows transfer active, bit 2 shift active.
package csio_pkg;
    // Register byte offsets
    localparam logic [11:0] CSIO_OFS_CR1 = 12'h000;
    localparam logic [11:0] CSIO_OFS_DBR = 12'h004;
    localparam logic [11:0] CSIO_OFS_CR2 = 12'h008;
    // First control register fields
    localparam int CSIO_CR1_START = 7;
    localparam int CSIO_CR1_MODE_HI = 5;
    localparam int CSIO_CR1_MODE_LO = 4;
    localparam int CSIO_CR1_INHIBIT = 3;
    localparam int CSIO_CR1_SCK_HI = 2;
    localparam int CSIO_CR1_SCK_LO = 0;
    // Second control / status fields
    localparam int CSIO_SR_ACTIVE = 3;
    localparam int CSIO_SR_SHIFT = 2;
    localparam int CSIO_CR2_IFM_HI = 3;
    localparam int CSIO_CR2_IFM_LO = 2;
    localparam logic [31:0] CSIO_SR_ONES = 32'h0000_00F3;
    // Reset values, external clock select code and bits per frame
    localparam logic [7:0] CSIO_CR1_RST = 8'h08;
    localparam logic [1:0] CSIO_IFM_RST = 2'h0;
    localparam logic [2:0] CSIO_SCK_EXT = 3'h7;
    localparam logic [3:0] CSIO_BITS = 4'h8;
    // Interface modes
    localparam logic [1:0] CSIO_IFM_PORT = 2'h0;
    localparam logic [1:0] CSIO_IFM_SERIAL = 2'h1;
    localparam logic [1:0] CSIO_IFM_TWOWIRE = 2'h2;

    // Transfer modes
    typedef enum logic [1:0] {
        CSIO_XM_TX = 2'b00,
        CSIO_XM_RSV = 2'b01,
        CSIO_XM_TXRX = 2'b10,
        CSIO_XM_RX = 2'b11
    } csio_xmode_t;

    // Engine states
    typedef enum logic [1:0] {
        CSIO_ST_IDLE = 2'b00,
        CSIO_ST_SHIFT = 2'b01,
        CSIO_ST_WAIT = 2'b10
    } csio_state_t;

    // Serial pin group
    typedef struct packed {
        logic sck_o;
        logic sck_oe;
        logic so_o;
        logic so_oe;
    } csio_pins_t;
endpackage

// ===== hdl/csio_top.sv
// Clocked serial transfer engine with APB register access
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module csio_top #(
    parameter int DIV_BASE = 2
) (
    // APB clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial pins
    input wire logic serial_clock_pin_i,
    input wire logic serial_in_pin_i,
    output csio_pkg::csio_pins_t pins,
    // Byte event
    output logic serial_irq
);
    import csio_pkg::*;

    logic [7:0] cr1_reg;
    logic [1:0] ifm_reg;
    logic [7:0] dbr_reg;
    logic [7:0] dbr_next;
    logic buf_full_reg;
    logic rd_pend_reg;
    logic [7:0] sh_reg;
    logic [3:0] cnt_reg;
    logic active_reg;
    logic shift_reg_flag;
    logic so_reg;
    logic sck_reg;
    logic irq_reg;
    logic [9:0] div_reg;
    csio_state_t st_reg;
    logic [1:0] sck_sync_reg;
    logic [1:0] si_sync_reg;
    logic ext_prev_reg;

    // APB decode
    wire logic wr_en = psel & penable & pwrite;
    wire logic rd_en = psel & penable & ~pwrite;
    wire logic hit_cr1 = (paddr == CSIO_OFS_CR1);
    wire logic hit_dbr = (paddr == CSIO_OFS_DBR);
    wire logic hit_cr2 = (paddr == CSIO_OFS_CR2);
    wire logic hit_any = hit_cr1 | hit_dbr | hit_cr2;
    wire logic wr_cr1 = wr_en & hit_cr1;
    wire logic wr_dbr = wr_en & hit_dbr;
    wire logic rd_dbr = rd_en & hit_dbr;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit_any;

    // Control fields
    wire logic start_bit = cr1_reg[CSIO_CR1_START];
    wire logic inhibit_bit = cr1_reg[CSIO_CR1_INHIBIT];
    wire logic [1:0] transfer_mode_field = cr1_reg[CSIO_CR1_MODE_HI:CSIO_CR1_MODE_LO];
    wire logic [2:0] sck_sel = cr1_reg[CSIO_CR1_SCK_HI:CSIO_CR1_SCK_LO];
    wire logic ext_clk = (sck_sel == CSIO_SCK_EXT);
    wire logic serial_on = (ifm_reg == CSIO_IFM_SERIAL);
    wire logic mode_tx = (transfer_mode_field == CSIO_XM_TX);
    wire logic mode_rx = (transfer_mode_field == CSIO_XM_RX);
    wire logic mode_txrx = (transfer_mode_field == CSIO_XM_TXRX);
    wire logic sends = mode_tx | mode_txrx;

    // Pin synchronisers: first stage feeds only the second
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sck_sync_reg <= 2'b11;
            si_sync_reg <= 2'b00;
        end
        else
        begin
            sck_sync_reg <= {sck_sync_reg[0], serial_clock_pin_i};
            si_sync_reg <= {si_sync_reg[0], serial_in_pin_i};
        end
    end

    // Edge detection on the synchronised external clock; relies on slow external phases
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ext_prev_reg <= 1'b1;
        else
            ext_prev_reg <= sck_sync_reg[1];
    end
    wire logic ext_fall = ext_prev_reg & ~sck_sync_reg[1];
    wire logic ext_rise = ~ext_prev_reg & sck_sync_reg[1];

    // Internal rate: half period of DIV_BASE << select, seven rates
    wire logic [9:0] half_per = 10'(DIV_BASE << sck_sel);
    wire logic div_tick = (div_reg >= half_per - 10'h001);
    wire logic int_fall = ~ext_clk & div_tick & sck_reg;
    wire logic int_rise = ~ext_clk & div_tick & ~sck_reg;
    wire logic fall_ev = ext_clk ? ext_fall : int_fall;
    wire logic rise_ev = ext_clk ? ext_rise : int_rise;

    // Buffer ready for the next frame depends on the mode
    wire logic tx_ready = buf_full_reg;
    wire logic rx_ready = ~buf_full_reg;
    wire logic buf_ok = mode_rx ? rx_ready : (mode_tx ? tx_ready : (tx_ready & ~rd_pend_reg));
    wire logic last_bit = (cnt_reg == CSIO_BITS - 4'h1);
    wire logic go = serial_on & start_bit & ~inhibit_bit & ~active_reg
                    & (mode_rx | buf_full_reg);

    // Next buffer contents: received byte wins over a software write
    always_comb
    begin
        dbr_next = dbr_reg;
        if (wr_dbr)
            dbr_next = pwdata[7:0];
        if (st_reg == CSIO_ST_SHIFT && rise_ev && last_bit && !mode_tx)
            dbr_next = {si_sync_reg[1], sh_reg[7:1]};
    end

    // Register writes and buffer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cr1_reg <= CSIO_CR1_RST;
            ifm_reg <= CSIO_IFM_RST;
            dbr_reg <= 8'h00;
        end
        else
        begin
            if (wr_cr1)
                cr1_reg <= pwdata[7:0];
            if (wr_en && hit_cr2)
                ifm_reg <= pwdata[CSIO_CR2_IFM_HI:CSIO_CR2_IFM_LO];
            dbr_reg <= dbr_next;
        end
    end

    // Internal clock divider and pin; pin held high when idle or stalled
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_reg <= 10'h000;
            sck_reg <= 1'b1;
        end
        else if (st_reg != CSIO_ST_SHIFT || ext_clk)
        begin
            div_reg <= 10'h000;
            sck_reg <= 1'b1;
        end
        else if (div_tick)
        begin
            div_reg <= 10'h000;
            sck_reg <= ~sck_reg;
        end
        else
            div_reg <= div_reg + 10'h001;
    end

    // Transfer engine
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_reg <= CSIO_ST_IDLE;
            sh_reg <= 8'h00;
            cnt_reg <= 4'h0;
            active_reg <= 1'b0;
            shift_reg_flag <= 1'b0;
            so_reg <= 1'b1;
            buf_full_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            irq_reg <= 1'b0;
        end
        else
        begin
            irq_reg <= 1'b0;
            // Software writes fill the buffer in sending modes and empty it in receive mode, reads of a received byte empty it
            if (wr_dbr)
                buf_full_reg <= sends;
            if (rd_dbr)
            begin
                rd_pend_reg <= 1'b0;
                // Duplex buffer counts as empty once read, until the next byte is written
                if (mode_rx || mode_txrx)
                    buf_full_reg <= 1'b0;
            end
            if (inhibit_bit || !serial_on)
            begin
                // Abort at once; partial byte is dropped
                st_reg <= CSIO_ST_IDLE;
                active_reg <= 1'b0;
                shift_reg_flag <= 1'b0;
                cnt_reg <= 4'h0;
            end
            else
            begin
                case (st_reg)
                    CSIO_ST_IDLE:
                    begin
                        if (go)
                        begin
                            // so_reg untouched: old last bit stays out
                            active_reg <= 1'b1;
                            shift_reg_flag <= 1'b1;
                            cnt_reg <= 4'h0;
                            st_reg <= CSIO_ST_SHIFT;
                            if (sends)
                            begin
                                sh_reg <= dbr_reg;
                                buf_full_reg <= wr_dbr;
                                irq_reg <= mode_tx;
                            end
                        end
                    end
                    CSIO_ST_SHIFT:
                    begin
                        if (fall_ev && sends)
                            so_reg <= sh_reg[0];
                        if (rise_ev)
                        begin
                            sh_reg <= {si_sync_reg[1], sh_reg[7:1]};
                            cnt_reg <= cnt_reg + 4'h1;
                            if (last_bit)
                            begin
                                cnt_reg <= 4'h0;
                                shift_reg_flag <= 1'b0;
                                if (!mode_tx)
                                begin
                                    buf_full_reg <= 1'b1;
                                    rd_pend_reg <= mode_txrx;
                                    irq_reg <= 1'b1;
                                end
                                // Stop cleanly once the byte is finished
                                if (!start_bit)
                                begin
                                    active_reg <= 1'b0;
                                    st_reg <= CSIO_ST_IDLE; // so_reg keeps last bit
                                end
                                else
                                    st_reg <= CSIO_ST_WAIT;
                            end
                        end
                    end
                    CSIO_ST_WAIT:
                    begin
                        // Internal clock stalls here until serviced
                        if (!start_bit)
                        begin
                            active_reg <= 1'b0;
                            st_reg <= CSIO_ST_IDLE;
                        end
                        else if (buf_ok || (ext_clk && fall_ev))
                        begin
                            // External clock cannot wait: stale data goes out
                            shift_reg_flag <= 1'b1;
                            st_reg <= CSIO_ST_SHIFT;
                            if (sends)
                            begin
                                sh_reg <= dbr_reg;
                                buf_full_reg <= wr_dbr; // A write in this very cycle stays pending
                                irq_reg <= mode_tx;
                                if (ext_clk && fall_ev)
                                    so_reg <= dbr_reg[0];
                            end
                            else
                                buf_full_reg <= 1'b0;
                        end
                    end
                    default:
                        st_reg <= CSIO_ST_IDLE;
                endcase
            end
        end
    end

    // Status word: bit 3 transfer, bit 2 shift
    wire logic [31:0] sr_word = CSIO_SR_ONES
        | (32'(active_reg) << CSIO_SR_ACTIVE)
        | (32'(shift_reg_flag) << CSIO_SR_SHIFT);
    assign prdata = !rd_en ? 32'h0000_0000
                  : hit_cr1 ? {24'h00_0000, cr1_reg}
                  : hit_dbr ? {24'h00_0000, dbr_reg}
                  : hit_cr2 ? sr_word
                  : 32'h0000_0000;

    // Pins: clock driven only in internal mode
    // One driver for the whole pin group
    assign pins = '{sck_o: sck_reg, sck_oe: serial_on & ~ext_clk,
                    so_o: so_reg, so_oe: serial_on};
    assign serial_irq = irq_reg;
endmodule // csio_top
`default_nettype wire

// ===== tb/csio_props.sv
// Port-level assertions for the clocked serial block
`timescale 1ns/1ps
`default_nettype none
module csio_props
    import csio_pkg::*;
#(
    parameter int DIV_BASE = 2
) (
    // APB side
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Serial side
    input wire logic serial_clock_pin_i,
    input wire logic serial_in_pin_i,
    input wire csio_pkg::csio_pins_t pins,
    input wire logic serial_irq
);
    import csio_pkg::*;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Access phase, and a read access to one place
    sequence s_acc;
        psel && penable;
    endsequence
    sequence s_rd(logic [11:0] a);
        s_acc ##0 (!pwrite && paddr == a);
    endsequence
    // Bus answers
    property p_ready; s_acc |-> pready; endproperty
    a_ready: assert property (p_ready) else $error("access phase not answered");
    property p_slverr; s_acc |-> pslverr == !(paddr inside {12'h000, 12'h004, 12'h008}); endproperty
    a_slverr: assert property (p_slverr) else $error("error response wrong for address");
    property p_quiet; !(psel && penable && !pwrite) |-> prdata == 32'h0000_0000; endproperty
    a_quiet: assert property (p_quiet) else $error("read data outside a read access");
    property p_status; s_rd(CSIO_OFS_CR2) |-> (prdata & 32'hFFFF_FFF3) == CSIO_SR_ONES; endproperty
    a_status: assert property (p_status) else $error("status constant bits wrong");
    // Serial pins; a low phase can never outlast the slowest half period
    property p_irq; serial_irq |=> !serial_irq; endproperty
    a_irq: assert property (p_irq) else $error("byte event longer than one cycle");
    property p_start_high; $rose(pins.sck_oe) |-> pins.sck_o; endproperty
    a_start_high: assert property (p_start_high) else $error("clock not high at enable");
    property p_low_bound; pins.sck_oe && $fell(pins.sck_o) |-> ##[1:300] pins.sck_o; endproperty
    a_low_bound: assert property (p_low_bound) else $error("clock stalled low");
    property p_so_fall; pins.sck_oe && $changed(pins.so_o) |-> !pins.sck_o; endproperty
    a_so_fall: assert property (p_so_fall) else $error("data out moved while clock high");
    property p_oe_pair; pins.sck_oe |-> pins.so_oe; endproperty
    a_oe_pair: assert property (p_oe_pair) else $error("clock driven outside serial mode");
endmodule // csio_props
bind csio_top csio_props #(.DIV_BASE(DIV_BASE)) i_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_clock_pin_i(serial_clock_pin_i),
    .serial_in_pin_i(serial_in_pin_i), .pins(pins), .serial_irq(serial_irq));
`default_nettype wire

// ===== tb/csio_peer.sv
// Behavioural model of the external clocked serial peer
`timescale 1ns/1ps
`default_nettype none
module csio_peer (
    // From the device
    input wire logic sck,
    input wire logic so,
    // Towards the device
    output logic sck_ext,
    output logic sin
);
    logic [7:0] tx_reg;
    logic [7:0] rx_reg;
    initial
    begin
        sck_ext = 1'b1;
        sin = 1'b1;
        tx_reg = 8'h00;
        rx_reg = 8'h00;
    end
    // Vacated bits refill inverted, so stale data never looks like a byte
    always @(negedge sck)
    begin
        sin <= tx_reg[0];
        tx_reg <= {~tx_reg[0], tx_reg[7:1]};
    end
    // Device data taken on rising edges, least significant bit first
    always @(posedge sck)
        rx_reg <= {so, rx_reg[7:1]};
    task automatic load(input logic [7:0] b);
        tx_reg = b;
    endtask
    // Clock stands high between frames; 105 ns phases stay just above four pclk
    task automatic pulse(input int n);
        repeat (n)
        begin
            #105;
            sck_ext = 1'b0;
            #105;
            sck_ext = 1'b1;
        end
    endtask
endmodule // csio_peer
`default_nettype wire

// ===== tb/csio_tb_top.sv
// Self-checking bench for the clocked serial block and its peer
`timescale 1ns/1ps
`default_nettype none
module csio_tb_top;
    import csio_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, serr;
    logic sck_ext, sck_wire, sin, serial_irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    csio_pins_t pins;
    int errors, n_checks;
    // Pin level: device while it drives, otherwise the peer
    assign sck_wire = pins.sck_oe ? pins.sck_o : sck_ext;
    csio_top #(.DIV_BASE(2)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .serial_clock_pin_i(sck_wire),
        .serial_in_pin_i(sin), .pins(pins), .serial_irq(serial_irq));
    csio_peer i_peer (.sck(sck_wire), .so(pins.so_o), .sck_ext(sck_ext), .sin(sin));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer, held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Let the write settle before any pin is looked at
        @(negedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, e);
    endtask
    task automatic wait_irq;
        int n;
        n = 0;
        while (serial_irq !== 1'b1 && n < 3000)
        begin
            @(negedge pclk);
            n++;
        end
        chk(32'(serial_irq), 32'h0000_0001);
    endtask
    task automatic wait_idle;
        int n;
        n = 0;
        rd = 32'h0000_0008;
        while (rd[CSIO_SR_ACTIVE] !== 1'b0 && n < 400)
        begin
            apb(1'b0, CSIO_OFS_CR2, 32'h0000_0000);
            n++;
        end
        chk(rd, CSIO_SR_ONES);
    endtask
    task automatic t_reset;
        rchk(CSIO_OFS_CR2, CSIO_SR_ONES);
        chk(32'(pins.so_oe), 32'h0000_0000);
        apb(1'b0, 12'h00C, 32'h0000_0000);
        chk(32'(serr), 32'h0000_0001);
        wr(CSIO_OFS_CR2, 32'h0000_0004);
        chk(32'(pins.so_oe), 32'h0000_0001);
        $display("test reset done");
    endtask
    task automatic t_tx;
        wr(CSIO_OFS_CR1, 32'h0000_0008);
        wr(CSIO_OFS_DBR, 32'h0000_00A5);
        wr(CSIO_OFS_CR1, 32'h0000_0080);
        wait_irq();
        chk(32'(pins.sck_oe), 32'h0000_0001);
        repeat (52) @(posedge pclk);
        chk(32'(i_peer.rx_reg), 32'h0000_00A5);
        chk(32'(pins.sck_o), 32'h0000_0001);
        apb(1'b0, CSIO_OFS_CR2, 32'h0000_0000);
        chk(32'(rd[CSIO_SR_ACTIVE]), 32'h0000_0001);
        wr(CSIO_OFS_DBR, 32'h0000_003C);
        wr(CSIO_OFS_CR1, 32'h0000_0000);
        wait_idle();
        chk(32'(i_peer.rx_reg), 32'h0000_003C);
        chk(32'(pins.so_o), 32'h0000_0000);
        $display("test tx done");
    endtask
    task automatic t_rx;
        i_peer.load(8'h96);
        wr(CSIO_OFS_CR1, 32'h0000_0038);
        wr(CSIO_OFS_CR1, 32'h0000_00B1);
        wait_irq();
        wr(CSIO_OFS_CR1, 32'h0000_0031);
        rchk(CSIO_OFS_DBR, 32'h0000_0096);
        wait_idle();
        wr(CSIO_OFS_CR1, 32'h0000_00B1);
        repeat (10) @(posedge pclk);
        wr(CSIO_OFS_CR1, 32'h0000_0039);
        rchk(CSIO_OFS_CR2, CSIO_SR_ONES);
        $display("test rx done");
    endtask
    task automatic t_txrx;
        wr(CSIO_OFS_CR1, 32'h0000_002F);
        chk(32'(pins.sck_oe), 32'h0000_0000);
        wr(CSIO_OFS_DBR, 32'h0000_005A);
        i_peer.load(8'hC3);
        wr(CSIO_OFS_CR1, 32'h0000_00A7);
        fork
            i_peer.pulse(8);
            wait_irq();
        join
        chk(32'(i_peer.rx_reg), 32'h0000_005A);
        rchk(CSIO_OFS_DBR, 32'h0000_00C3);
        rchk(CSIO_OFS_CR2, CSIO_SR_ONES | 32'h0000_0008);
        wr(CSIO_OFS_CR1, 32'h0000_002F);
        rchk(CSIO_OFS_CR2, CSIO_SR_ONES);
        $display("test txrx done");
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // 40 MHz clock
    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // Watchdog well beyond the expected run
    initial
    begin
        #2000000;
        errors++;
        conclude();
    end
    // Main sequence
    initial
    begin
        errors = 0;
        n_checks = 0;
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_tx();
        t_rx();
        t_txrx();
        conclude();
    end
endmodule // csio_tb_top
`default_nettype wire
